// ===== shared/cascade_irq_consts.vh
// Summary of operation
// - Internal sources go to a polled local controller.
// - Any unmasked local pending request raises system level seven.
// - Local fixed priority, level zero most urgent.
// - Levels 0-3 are serial channel receive/transmit ready.
// - Levels 4-6 tick, parallel, io; seven unused.
// - System controller fully nested, blocks equal/lower.
// - Vector equals base zero plus eight times level.
// - System vectors 00H to 38H; 38H is local.
// - Variant b lets remote masters reach local only.
// - Requests held and latched while bus elsewhere.
// - Panel and internal requests driven onto bus lines.
// - Panel, bus and internal requests share one ranking.
// - Software mask blocks processor, requests stay pending.
`ifndef CASCADE_IRQ_CONSTS_VH
`define CASCADE_IRQ_CONSTS_VH

// Register byte offsets
`define OFS_LOC_POLL 8'h00
`define OFS_LOC_MASK 8'h04
`define OFS_LOC_EOI 8'h08
`define OFS_LOC_STAT 8'h0C
`define OFS_SYS_ACK 8'h10
`define OFS_SYS_MASK 8'h14
`define OFS_SYS_EOI 8'h18
`define OFS_SYS_STAT 8'h1C
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_MASK 8'h24

// Reset values
`define RST_LOC_MASK 8'h00
`define RST_SYS_MASK 9'h000
`define RST_IRQ_MASK 3'h0

// Field positions and levels
`define LVL_W 3
`define NLVL 8
`define LOC_SRC_N 7
`define CASCADE_LVL 3'h7
`define POLL_VALID_BIT 7
`define ACK_VALID_BIT 31
`define GLOBAL_MASK_BIT 8
`define VEC_BASE 16'h0000
`define VEC_SHIFT 3
`define STAT_ISR_LSB 8

// Pin synchroniser layout
`define SYNC_W 24
`define SY_PANEL 7
`define SY_BUS 14
`define SY_AWAY 22
`define SY_VARB 23

// Interrupt status bits
`define EV_LOCREQ 0
`define EV_CPUREQ 1
`define EV_REFUSE 2
`define EV_N 3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// ===== hw/prio_pick_eight.v
`default_nettype none

// Fixed priority pick among eight levels, level zero wins
module prio_pick_eight (
  input wire [7:0] req,
  output reg anyReq,
  output reg [2:0] topLevel
);

  integer i;

  // Scan downward so the lowest set index is left last
  always @* begin
    anyReq = 1'b0;
    topLevel = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (req[i]) begin
        anyReq = 1'b1;
        topLevel = i[2:0];
      end
    end
  end

endmodule

`default_nettype wire

// ===== hw/cascaded_interrupt_structure.v
// The implementer's own choices: the address map and the AXI4-Lite register port.
`include "cascade_irq_consts.vh"
`default_nettype none

module cascaded_interrupt_structure (
  input wire sys_clk,
  input wire rst_n,
  // Internal sources: ch0 rx, ch0 tx, ch1 rx, ch1 tx, tick, parallel, io
  input wire [6:0] srcReq,
  input wire [6:0] panelSw,
  input wire [7:0] busIntIn,
  output wire [7:0] busIntOut,
  output wire [7:0] busIntOeN,
  input wire busAwayPin,
  input wire variantPin,
  output wire cpuIntReq,
  output wire irq,
  input wire axiRemote,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  reg [`SYNC_W-1:0] syncA_ff, syncB_ff, syncC_ff, clean_ff;
  reg variantB_ff;
  reg [7:0] locPend_ff, nxt_locPend, locIsr_ff, nxt_locIsr, locMask_ff;
  reg [7:0] sysPend_ff, nxt_sysPend, sysIsr_ff, nxt_sysIsr;
  reg [8:0] sysMask_ff;
  reg [7:0] busOeN_ff;
  reg cpuReq_ff, locReqD_ff;
  reg [`EV_N-1:0] evStat_ff, nxt_evStat, irqMask_ff;
  reg bvalid_ff, rvalid_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff, nxt_rdata;
  reg [1:0] nxt_rresp, nxt_bresp;
  wire [7:0] locSrc, locCand, sysSrc, sysCand;
  wire locAny, locIsrAny, sysAny, sysIsrAny, nestedOk, localReq, busAway;
  wire [2:0] locLvl, locIsrLvl, sysLvl, sysIsrLvl;
  wire wrTake, rdTake;
  reg wrLocOk, rdLocOk, wrSysOk, rdSysOk, refuse;
  reg pollHit, ackHit, locEoi, sysEoi, irqRdClr;
  wire [15:0] vecAddr;
  wire [`SYNC_W-1:0] pinRaw;

  // All outside pins in one word; bus lines are active low, so turn them request-high
  assign pinRaw = {variantPin, busAwayPin, ~busIntIn, panelSw, srcReq};

  // Three-stage pin synchronisers; value moves only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g = g + 1) begin : pinSync
      always @(posedge sys_clk) begin
        // Strap stages run through reset, else the strap would only ever read zero
        if (!rst_n && g != `SY_VARB) begin
          syncA_ff[g] <= 1'b0;
          syncB_ff[g] <= 1'b0;
          syncC_ff[g] <= 1'b0;
          clean_ff[g] <= 1'b0;
        end else begin
          syncA_ff[g] <= pinRaw[g];
          syncB_ff[g] <= syncA_ff[g];
          syncC_ff[g] <= syncB_ff[g];
          if (syncB_ff[g] == syncC_ff[g]) begin
            clean_ff[g] <= syncC_ff[g];
          end
        end
      end
    end
  endgenerate

  // Board variant strap, caught while reset is held; needs five clocks of reset
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      variantB_ff <= clean_ff[`SY_VARB];
    end
  end

  assign busAway = clean_ff[`SY_AWAY];
  // Level seven of the local controller has no source
  assign locSrc = {1'b0, clean_ff[`LOC_SRC_N-1:0]};
  assign locCand = locPend_ff & ~locMask_ff & ~locIsr_ff;
  // Any unmasked pending local request forwards as system level seven
  assign localReq = |(locPend_ff & ~locMask_ff);
  // Panel switches, bus lines and the local cascade form one request set
  assign sysSrc = clean_ff[`SY_AWAY-1:`SY_BUS] |
    {localReq, clean_ff[`SY_BUS-1:`SY_PANEL]};
  assign sysCand = sysPend_ff & ~sysMask_ff[`NLVL-1:0];

  prio_pick_eight locPick (
    .req(locCand),
    .anyReq(locAny),
    .topLevel(locLvl)
  );

  prio_pick_eight locIsrPick (
    .req(locIsr_ff),
    .anyReq(locIsrAny),
    .topLevel(locIsrLvl)
  );

  prio_pick_eight sysPick (
    .req(sysCand),
    .anyReq(sysAny),
    .topLevel(sysLvl)
  );

  prio_pick_eight sysIsrPick (
    .req(sysIsr_ff),
    .anyReq(sysIsrAny),
    .topLevel(sysIsrLvl)
  );

  // In-service level blocks its own and all less urgent levels
  assign nestedOk = sysAny && (!sysIsrAny || sysLvl < sysIsrLvl);
  // Spacing fixed at eight; no field exists to change it
  assign vecAddr = `VEC_BASE + ({13'h0000, sysLvl} << `VEC_SHIFT);

  // Handshakes: write address and data taken together, one of each in flight
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_wready = s_axi_awready;
  assign wrTake = s_axi_awready;
  assign s_axi_arready = !rvalid_ff;
  assign rdTake = s_axi_arvalid && !rvalid_ff;

  // Access rights: system side resident only; local open to remote on variant b
  always @* begin
    wrLocOk = !axiRemote || variantB_ff;
    rdLocOk = wrLocOk;
    wrSysOk = !axiRemote;
    rdSysOk = !axiRemote;
    refuse = 1'b0;
    pollHit = 1'b0;
    ackHit = 1'b0;
    irqRdClr = 1'b0;
    nxt_rdata = 32'h00000000;
    nxt_rresp = `RESP_OKAY;
    if (rdTake) begin
      if (s_axi_araddr == `OFS_LOC_POLL) begin
        if (rdLocOk) begin
          pollHit = locAny;
          nxt_rdata[`POLL_VALID_BIT] = locAny;
          nxt_rdata[2:0] = locAny ? locLvl : 3'h0;
        end else begin
          refuse = 1'b1;
        end
      end else if (s_axi_araddr == `OFS_LOC_MASK) begin
        if (rdLocOk) nxt_rdata[7:0] = locMask_ff;
        else refuse = 1'b1;
      end else if (s_axi_araddr == `OFS_LOC_STAT) begin
        if (rdLocOk) nxt_rdata[15:0] = {locIsr_ff, locPend_ff};
        else refuse = 1'b1;
      end else if (s_axi_araddr == `OFS_SYS_ACK) begin
        if (rdSysOk) begin
          ackHit = nestedOk;
          nxt_rdata[`ACK_VALID_BIT] = nestedOk;
          nxt_rdata[15:0] = nestedOk ? vecAddr : 16'h0000;
        end else begin
          refuse = 1'b1;
        end
      end else if (s_axi_araddr == `OFS_SYS_MASK) begin
        if (rdSysOk) nxt_rdata[8:0] = sysMask_ff;
        else refuse = 1'b1;
      end else if (s_axi_araddr == `OFS_SYS_STAT) begin
        if (rdSysOk) nxt_rdata[15:0] = {sysIsr_ff, sysPend_ff};
        else refuse = 1'b1;
      end else if (s_axi_araddr == `OFS_IRQ_STAT) begin
        if (rdSysOk) begin
          irqRdClr = 1'b1;
          nxt_rdata[`EV_N-1:0] = evStat_ff;
        end else begin
          refuse = 1'b1;
        end
      end else if (s_axi_araddr == `OFS_IRQ_MASK) begin
        if (rdSysOk) nxt_rdata[`EV_N-1:0] = irqMask_ff;
        else refuse = 1'b1;
      end else if (s_axi_araddr == `OFS_LOC_EOI || s_axi_araddr == `OFS_SYS_EOI) begin
        nxt_rresp = `RESP_OKAY; // Write-only: read as zero
      end else begin
        nxt_rresp = `RESP_DECERR;
      end
      if (refuse) nxt_rresp = `RESP_SLVERR;
    end
  end

  // Write decode; EOI writes need no data, the write itself is the command
  always @* begin
    locEoi = 1'b0;
    sysEoi = 1'b0;
    nxt_bresp = `RESP_OKAY;
    if (wrTake) begin
      if (s_axi_awaddr == `OFS_LOC_MASK || s_axi_awaddr == `OFS_LOC_EOI) begin
        if (!wrLocOk) nxt_bresp = `RESP_SLVERR;
        else locEoi = (s_axi_awaddr == `OFS_LOC_EOI);
      end else if (s_axi_awaddr == `OFS_SYS_MASK || s_axi_awaddr == `OFS_SYS_EOI ||
        s_axi_awaddr == `OFS_IRQ_MASK) begin
        if (!wrSysOk) nxt_bresp = `RESP_SLVERR;
        else sysEoi = (s_axi_awaddr == `OFS_SYS_EOI);
      end else if (s_axi_awaddr == `OFS_LOC_POLL || s_axi_awaddr == `OFS_LOC_STAT ||
        s_axi_awaddr == `OFS_SYS_ACK || s_axi_awaddr == `OFS_SYS_STAT ||
        s_axi_awaddr == `OFS_IRQ_STAT) begin
        nxt_bresp = `RESP_OKAY; // Read-only: write ignored
      end else begin
        nxt_bresp = `RESP_DECERR;
      end
    end
  end

  // Pending and in-service updates; a new request wins over a clear
  always @* begin
    nxt_locPend = (locPend_ff & ~({7'h00, pollHit} << locLvl)) | locSrc;
    nxt_locIsr = locIsr_ff;
    if (locEoi && locIsrAny) nxt_locIsr = nxt_locIsr & ~(8'h01 << locIsrLvl);
    if (pollHit) nxt_locIsr = nxt_locIsr | (8'h01 << locLvl);
    nxt_sysPend = (sysPend_ff & ~({7'h00, ackHit} << sysLvl)) | sysSrc;
    nxt_sysIsr = sysIsr_ff;
    if (sysEoi && sysIsrAny) nxt_sysIsr = nxt_sysIsr & ~(8'h01 << sysIsrLvl);
    if (ackHit) nxt_sysIsr = nxt_sysIsr | (8'h01 << sysLvl);
  end

  // Controller state
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      locPend_ff <= 8'h00;
      locIsr_ff <= 8'h00;
      sysPend_ff <= 8'h00;
      sysIsr_ff <= 8'h00;
    end else begin
      locPend_ff <= nxt_locPend;
      locIsr_ff <= nxt_locIsr;
      sysPend_ff <= nxt_sysPend;
      sysIsr_ff <= nxt_sysIsr;
    end
  end

  // Mask registers, low byte lane for eight bits, next lane for the global mask
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      locMask_ff <= `RST_LOC_MASK;
      sysMask_ff <= `RST_SYS_MASK;
      irqMask_ff <= `RST_IRQ_MASK;
    end else if (wrTake && nxt_bresp == `RESP_OKAY) begin
      if (s_axi_awaddr == `OFS_LOC_MASK && s_axi_wstrb[0]) locMask_ff <= s_axi_wdata[7:0];
      if (s_axi_awaddr == `OFS_SYS_MASK) begin
        if (s_axi_wstrb[0]) sysMask_ff[7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) sysMask_ff[8] <= s_axi_wdata[`GLOBAL_MASK_BIT];
      end
      if (s_axi_awaddr == `OFS_IRQ_MASK && s_axi_wstrb[0]) begin
        irqMask_ff <= s_axi_wdata[`EV_N-1:0];
      end
    end
  end

  // Processor request, withheld under global mask or while bus is elsewhere
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cpuReq_ff <= 1'b0;
      locReqD_ff <= 1'b0;
      busOeN_ff <= 8'hFF;
    end else begin
      cpuReq_ff <= nestedOk && !sysMask_ff[`GLOBAL_MASK_BIT] && !busAway;
      locReqD_ff <= localReq;
      // Open-drain lines pulled low for panel switches and the cascade
      busOeN_ff <= ~{localReq, clean_ff[`SY_BUS-1:`SY_PANEL]};
    end
  end

  assign cpuIntReq = cpuReq_ff;
  assign busIntOut = 8'h00;
  assign busIntOeN = busOeN_ff;

  // Sticky events, cleared by reading; a coincident event survives the read
  always @* begin
    nxt_evStat = irqRdClr ? {`EV_N{1'b0}} : evStat_ff;
    if (localReq && !locReqD_ff) nxt_evStat[`EV_LOCREQ] = 1'b1;
    if (nestedOk && !sysMask_ff[`GLOBAL_MASK_BIT] && !busAway && !cpuReq_ff) begin
      nxt_evStat[`EV_CPUREQ] = 1'b1;
    end
    if (refuse || (wrTake && nxt_bresp == `RESP_SLVERR)) nxt_evStat[`EV_REFUSE] = 1'b1;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) evStat_ff <= {`EV_N{1'b0}};
    else evStat_ff <= nxt_evStat;
  end

  assign irq = |(evStat_ff & irqMask_ff);

  // Bus answer channels, one cycle after the handshake
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      if (wrTake) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= nxt_bresp;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rdTake) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= nxt_rresp;
        rdata_ff <= nxt_rdata;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

endmodule

`default_nettype wire

// ===== verification/cascaded_interrupt_structure_sva.sv
`default_nettype none
module cis_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire [6:0] panelSw,
  input wire [7:0] busIntOut,
  input wire [7:0] busIntOeN,
  input wire busAwayPin,
  input wire cpuIntReq,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Write accepted on both channels, answered next cycle
  property p_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not answered");
  // Read accepted when idle, answered next cycle
  property p_rd_take;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read not answered");
  // Answers hold still while the master stalls
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  // Open-drain lines only ever pull low
  property p_od_zero;
    busIntOut == 8'h00;
  endproperty
  a_od_zero: assert property (p_od_zero) else $error("bus line driven high");
  // A held panel switch reaches its bus line after the synchroniser
  property p_panel_drive;
    panelSw[0] [*8] |-> !busIntOeN[0];
  endproperty
  a_panel_drive: assert property (p_panel_drive) else $error("panel not on bus");
  // Processor stays quiet while another master owns the bus
  property p_away_block;
    busAwayPin [*8] |-> !cpuIntReq;
  endproperty
  a_away_block: assert property (p_away_block) else $error("request while away");
endmodule
bind cascaded_interrupt_structure cis_checker u_chk (.sys_clk, .rst_n, .panelSw, .busIntOut,
  .busIntOeN, .busAwayPin, .cpuIntReq, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ===== verification/sys_bus_lines.sv
`default_nettype none
// Far side of the interrupt lines: other masters and pull-ups
module sys_bus_lines (
  input wire logic [7:0] busIntOut,
  input wire logic [7:0] busIntOeN,
  input wire logic [7:0] otherLow,
  output logic [7:0] busIntIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-AND; a released line floats back high
  assign busIntIn = ~(otherLow | (~busIntOeN & ~busIntOut));
endmodule
`default_nettype wire

// ===== verification/cascaded_interrupt_structure_tb.sv
`include "cascade_irq_consts.vh"
`default_nettype none
module cascaded_interrupt_structure_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [33:0] ALL = 34'h3FFFFFFFF;
  localparam logic [33:0] RSP = 34'h300000000;
  localparam logic [33:0] AK = 34'h38000FFFF;
  logic sys_clk = 1'h0, rst_n = 1'h0, variantPin = 1'h0, busAwayPin = 1'h0, axiRemote = 1'h0;
  logic [6:0] srcReq = 7'h00, panelSw = 7'h00, src;
  logic [7:0] otherLow = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire [7:0] busIntIn, busIntOut, busIntOeN;
  wire cpuIntReq, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [67:0] expR[$];
  logic [67:0] e;
  logic [1:0] expB[$];
  int n_fail = 0, samples_checked = 0, lvl;

  always #10 sys_clk = ~sys_clk;
  cascaded_interrupt_structure dut (.*);
  sys_bus_lines bus (.*);

  task automatic complete_run;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] x, input logic [33:0] m);
    samples_checked++;
    if ((g & m) !== (x & m)) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g & m, x & m);
    end
  endtask
  task automatic pin(input logic g, input logic x);
    chk({33'h0, g}, {33'h0, x}, 34'h1);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Strap must be steady through the whole reset
  task automatic do_reset(input logic v);
    rst_n <= 1'h0;
    variantPin <= v;
    wt(6);
    rst_n <= 1'h1;
  endtask
  // Master stalls the answer a random while to exercise holding
  task automatic axw(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    expB.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    wt($urandom % 3);
    s_axi_bready <= 1'h1;
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] x, input logic [33:0] m);
    expR.push_back({m, x});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    wt($urandom % 3);
    s_axi_rready <= 1'h1;
    @(posedge sys_clk);
    s_axi_rready <= 1'h0;
  endtask
  function automatic logic [33:0] ack(input int l);
    return {18'h08000, 10'h0, 3'(l), 3'h0};
  endfunction
  // Request pulse long enough to pass the synchroniser, then released
  task automatic pulse(input logic [6:0] p, input logic [7:0] b);
    panelSw <= p;
    otherLow <= b;
    wt(12);
    chk({27'h0, busIntOeN[6:0] & p}, 34'h0, 34'h7F);
    panelSw <= 7'h00;
    otherLow <= 8'h00;
    wt(12);
  endtask

  // Answers are matched in order against the oldest note
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = expR.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, e[33:0], e[67:34]);
    end
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, expB.pop_front()}, 34'h3);
  end

  // Run is well under a thousand cycles; far beyond that means a hang
  initial begin
    wt(20000);
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(77));
    do_reset(1'h0);
    axr(`OFS_LOC_MASK, 34'h0, ALL);
    axr(`OFS_SYS_MASK, 34'h0, ALL);
    axr(`OFS_IRQ_MASK, 34'h0, ALL);
    axr(8'h40, {`RESP_DECERR, 32'h0}, RSP);
    axw(8'h40, 32'h0, `RESP_DECERR);
    d = $urandom;
    axw(`OFS_LOC_MASK, d, `RESP_OKAY);
    axr(`OFS_LOC_MASK, {26'h0, d[7:0]}, ALL);
    axw(`OFS_LOC_MASK, 32'h0, `RESP_OKAY);
    // Random set of local sources, latched then polled in order
    src = 7'h00;
    while (src == 7'h00) src = 7'($urandom);
    srcReq <= src;
    wt(16);
    pin(cpuIntReq, 1'h1);
    pin(busIntOeN[7], 1'h0);
    axr(`OFS_SYS_ACK, ack(7), AK);
    srcReq <= 7'h00;
    wt(12);
    for (lvl = 0; lvl < 7; lvl++) if (src[lvl]) begin
      axr(`OFS_LOC_POLL, {27'h1, 4'h0, 3'(lvl)}, 34'h300000087);
      axw(`OFS_LOC_EOI, 32'h0, `RESP_OKAY);
    end
    axr(`OFS_LOC_POLL, 34'h0, 34'h300000080);
    axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    axr(`OFS_SYS_ACK, 34'h0, RSP);
    axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    // Every panel level answers with its own vector
    for (lvl = 0; lvl < 7; lvl++) begin
      pulse(7'h01 << lvl, 8'h00);
      axr(`OFS_SYS_ACK, ack(lvl), AK);
      axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    end
    // Level 3 in service holds off 5 but not a bus line at 1
    pulse(7'h08, 8'h00);
    axr(`OFS_SYS_ACK, ack(3), AK);
    pulse(7'h20, 8'h00);
    axr(`OFS_SYS_ACK, 34'h0, 34'h380000000);
    pulse(7'h00, 8'h02);
    axr(`OFS_SYS_ACK, ack(1), AK);
    axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    axr(`OFS_SYS_ACK, ack(5), AK);
    axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    // Request arriving while the bus is away is kept
    busAwayPin <= 1'h1;
    pulse(7'h01, 8'h00);
    pin(cpuIntReq, 1'h0);
    busAwayPin <= 1'h0;
    wt(12);
    pin(cpuIntReq, 1'h1);
    axw(`OFS_SYS_MASK, 32'h100, `RESP_OKAY);
    wt(4);
    pin(cpuIntReq, 1'h0);
    axr(`OFS_SYS_ACK, ack(0), AK);
    axw(`OFS_SYS_EOI, 32'h0, `RESP_OKAY);
    axw(`OFS_SYS_MASK, 32'h0, `RESP_OKAY);
    // Refused remote access: raise, clear, then mask the interrupt
    axr(`OFS_IRQ_STAT, 34'h0, RSP);
    axw(`OFS_IRQ_MASK, 32'h4, `RESP_OKAY);
    axiRemote <= 1'h1;
    axr(`OFS_LOC_STAT, {`RESP_SLVERR, 32'h0}, RSP);
    axiRemote <= 1'h0;
    pin(irq, 1'h1);
    axr(`OFS_IRQ_STAT, 34'h4, 34'h300000004);
    pin(irq, 1'h0);
    axw(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
    axiRemote <= 1'h1;
    axw(`OFS_LOC_MASK, 32'hFF, `RESP_SLVERR);
    axiRemote <= 1'h0;
    pin(irq, 1'h0);
    axr(`OFS_IRQ_STAT, 34'h4, 34'h300000004);
    // Second variant: remote reaches the local side only
    do_reset(1'h1);
    axiRemote <= 1'h1;
    axr(`OFS_LOC_STAT, 34'h0, ALL);
    axr(`OFS_SYS_STAT, {`RESP_SLVERR, 32'h0}, RSP);
    axiRemote <= 1'h0;
    complete_run();
  end
endmodule
`default_nettype wire
